/* shared/rivs_defs.vh */
// Constants for the reset and interrupt vector address selector
`ifndef RIVS_DEFS_VH
`define RIVS_DEFS_VH

// ----------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------
`define RIVS_AW 14
`define RIVS_NSRC 25
`define RIVS_IDW 5

// ----------------------------------------------------------------
// Addresses (program words)
// ----------------------------------------------------------------
`define RIVS_RESET_ADDR 14'h0000
`define RIVS_BOOT_ADDR_NARROW 14'h0C00
`define RIVS_BOOT_ADDR_WIDE 14'h1C00
`define RIVS_APP_BASE 14'h0000

// ----------------------------------------------------------------
// Vector numbering and fuse encoding
// ----------------------------------------------------------------
`define RIVS_FIRST_IRQ_VEC 5'h02
`define RIVS_FUSE_PROGRAMMED 1'b0

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define RIVS_CCR_CE_BIT 0
`define RIVS_CCR_SEL_BIT 1
`define RIVS_SEL_RESET 1'b0
`define RIVS_CE_WINDOW 3'h4
// Edges after reset release before the straps are taken
`define RIVS_STRAP_WAIT 2'h2

`endif

/* verilog/rivs_prio_enc.v */
// Fixed-priority encoder: lowest set request index wins
`timescale 1ns/1ns
module rivs_prio_enc #(
  parameter WIDTH = 25,
  parameter IDW = 5
) (
  // Requests
  input wire [WIDTH-1:0] req,
  // Winner
  output reg found,
  output reg [IDW-1:0] index
);

  integer i;

  // Scan from the top so the lowest index is the last to assign
  always @* begin
    found = 1'b0;
    index = {IDW{1'b0}};
    for (i = WIDTH - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        found = 1'b1;
        index = i[IDW-1:0];
      end
    end
  end

endmodule

/* verilog/rivs_vector_sel.v */
// Reset and interrupt vector address selector with vector table move guard
`timescale 1ns/1ns
`include "rivs_defs.vh"

module rivs_vector_sel (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Straps from pins
  input wire boot_reset_fuse,
  input wire variant_wide,
  // Control register write and retire strobe from the core
  input wire ccr_wr,
  input wire [1:0] ccr_wdata,
  input wire instr_done,
  // Interrupt requests, bit 0 is vector 2
  input wire [`RIVS_NSRC-1:0] irq_req,
  // Addresses and grant to the core
  output reg [`RIVS_AW-1:0] reset_addr,
  output reg [`RIVS_AW-1:0] vector_addr,
  output reg irq_valid,
  output reg [`RIVS_IDW-1:0] irq_vec_num,
  // Control state
  output wire vector_table_select,
  output wire vector_change_enable,
  output wire irq_block
);

  // ----------------------------------------------------------------
  // Guard states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_WINDOW = 2'b01;
  localparam ST_AFTER = 2'b10;

  reg [1:0] fuse_meta_q;
  reg [1:0] wide_meta_q;
  reg fuse_q;
  reg wide_q;
  reg strap_taken_q;
  reg [1:0] strap_cnt_q;
  reg sel_q;
  reg sel_d;
  reg ce_bit_q;
  reg ce_bit_d;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] win_q;
  reg [2:0] win_d;
  wire [`RIVS_AW-1:0] boot_addr;
  wire [`RIVS_AW-1:0] table_base;
  wire [`RIVS_NSRC-1:0] req_gated;
  wire found;
  wire [`RIVS_IDW-1:0] win_idx;
  wire [`RIVS_AW-1:0] idx_ext;
  wire [`RIVS_AW-1:0] slot_off;

  // ----------------------------------------------------------------
  // Strap synchronisers and capture after reset release
  // ----------------------------------------------------------------
  // Straps come from pins, so two flops before any use
  always @(posedge clk) begin
    if (rst) begin
      fuse_meta_q <= 2'h3;
      wide_meta_q <= 2'h0;
    end else if (ce) begin
      fuse_meta_q <= {fuse_meta_q[0], boot_reset_fuse};
      wide_meta_q <= {wide_meta_q[0], variant_wide};
    end
  end

  // Fuse is read once per reset; mid-run changes must not move the reset entry
  // Capture waits until the pin value has passed both stages, not their reset value
  always @(posedge clk) begin
    if (rst) begin
      fuse_q <= 1'b1;
      wide_q <= 1'b0;
      strap_taken_q <= 1'b0;
      strap_cnt_q <= 2'h0;
    end else if (ce && !strap_taken_q) begin
      if (strap_cnt_q == `RIVS_STRAP_WAIT) begin
        fuse_q <= fuse_meta_q[1];
        wide_q <= wide_meta_q[1];
        strap_taken_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Vector table move sequence
  // ----------------------------------------------------------------
  // Select only changes inside the enable window, guarding stray writes
  always @* begin
    st_d = st_q;
    win_d = win_q;
    sel_d = sel_q;
    ce_bit_d = ce_bit_q;
    case (st_q)
      ST_IDLE: begin
        if (ccr_wr && ccr_wdata[`RIVS_CCR_CE_BIT]) begin
          ce_bit_d = 1'b1;
          win_d = `RIVS_CE_WINDOW;
          st_d = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        if (ccr_wr && !ccr_wdata[`RIVS_CCR_CE_BIT]) begin
          sel_d = ccr_wdata[`RIVS_CCR_SEL_BIT];
          ce_bit_d = 1'b0;
          st_d = ST_AFTER;
        end else if (ccr_wr) begin
          win_d = `RIVS_CE_WINDOW;
        end else if (win_q == 3'h1) begin
          // No select write came: window closes, blocking ends
          ce_bit_d = 1'b0;
          win_d = 3'h0;
          st_d = ST_IDLE;
        end else begin
          win_d = win_q - 3'h1;
        end
      end
      ST_AFTER: begin
        // Hold off until the instruction after the select write retires
        if (instr_done) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
        ce_bit_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      win_q <= 3'h0;
      sel_q <= `RIVS_SEL_RESET;
      ce_bit_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      win_q <= win_d;
      sel_q <= sel_d;
      ce_bit_q <= ce_bit_d;
    end
  end

  assign vector_table_select = sel_q;
  assign vector_change_enable = ce_bit_q;
  // Blocks from the enable cycle on; the core's global flag is never touched
  assign irq_block = (st_q != ST_IDLE);

  // ----------------------------------------------------------------
  // Priority choice
  // ----------------------------------------------------------------
  assign req_gated = irq_block ? {`RIVS_NSRC{1'b0}} : irq_req;

  rivs_prio_enc #(
    .WIDTH(`RIVS_NSRC),
    .IDW(`RIVS_IDW)
  ) u_prio (
    .req(req_gated),
    .found(found),
    .index(win_idx)
  );

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  // Boot start depends on the variant; narrow part uses a 2K boot section
  assign boot_addr = wide_q ? `RIVS_BOOT_ADDR_WIDE : `RIVS_BOOT_ADDR_NARROW;
  // Table moves as a whole, each entry keeps its offset
  assign table_base = sel_q ? boot_addr : `RIVS_APP_BASE;
  // Slot of vector n sits (n-1) entries in; index 0 is vector 2
  assign idx_ext = {{(`RIVS_AW-`RIVS_IDW){1'b0}}, win_idx} + 14'h0001;
  // Two words per entry in the wide variant, one in the narrow
  assign slot_off = wide_q ? {idx_ext[`RIVS_AW-2:0], 1'b0} : idx_ext;

  // Outputs registered so the core sees stable values
  always @(posedge clk) begin
    if (rst) begin
      reset_addr <= `RIVS_RESET_ADDR;
      vector_addr <= `RIVS_APP_BASE;
      irq_valid <= 1'b0;
      irq_vec_num <= 5'h00;
    end else if (ce) begin
      // Fuse zero means programmed, so reset enters the boot loader
      if (fuse_q == `RIVS_FUSE_PROGRAMMED) begin
        reset_addr <= boot_addr;
      end else begin
        reset_addr <= `RIVS_RESET_ADDR;
      end
      // Fixed map: every source lands at base plus its slot
      vector_addr <= table_base + slot_off;
      irq_valid <= found;
      irq_vec_num <= win_idx + `RIVS_FIRST_IRQ_VEC;
    end
  end

endmodule

/* bench/rivs_vector_sel_assertions.sv */
// Port-level checks on the vector address selector
`timescale 1ns/1ns
`include "rivs_defs.vh"
// ----------------------------------------------------------------
// Checker
// ----------------------------------------------------------------
module rivs_vector_sel_chk (
  // Clock, reset and enable
  input wire clk,
  input wire rst,
  input wire ce,
  // Selector inputs
  input wire boot_reset_fuse,
  input wire variant_wide,
  input wire ccr_wr,
  input wire [1:0] ccr_wdata,
  input wire instr_done,
  input wire [`RIVS_NSRC-1:0] irq_req,
  // Selector outputs
  input wire [`RIVS_AW-1:0] reset_addr,
  input wire [`RIVS_AW-1:0] vector_addr,
  input wire irq_valid,
  input wire [`RIVS_IDW-1:0] irq_vec_num,
  input wire vector_table_select,
  input wire vector_change_enable,
  input wire irq_block
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Enable write, then four cycles with no write at all
  sequence s_en; ccr_wr && ccr_wdata[0]; endsequence
  sequence s_quiet; (!ccr_wr) [*4]; endsequence
  property p_idle; irq_req == 0 |=> !irq_valid; endproperty
  a_idle: assert property (p_idle) else $error("grant with no request");
  property p_win; irq_req[0] && !irq_block |=> irq_valid && irq_vec_num == `RIVS_FIRST_IRQ_VEC;
  endproperty
  a_win: assert property (p_win) else $error("first source lost");
  property p_blk; irq_block |=> !irq_valid; endproperty
  a_blk: assert property (p_blk) else $error("grant while blocked");
  property p_cen; s_en |=> vector_change_enable && irq_block; endproperty
  a_cen: assert property (p_cen) else $error("enable write not taken");
  property p_tmo; s_en ##1 s_quiet |=> !irq_block; endproperty
  a_tmo: assert property (p_tmo) else $error("block outlived window");
  property p_ign; ccr_wr && !ccr_wdata[0] && !vector_change_enable |=> $stable(vector_table_select);
  endproperty
  a_ign: assert property (p_ign) else $error("unguarded select change");
  property p_sel; ccr_wr && !ccr_wdata[0] && vector_change_enable |=>
    vector_table_select == $past(ccr_wdata[1]) && !vector_change_enable; endproperty
  a_sel: assert property (p_sel) else $error("select write lost");
  // Application table: one or two words per vector from zero
  property p_map; irq_valid && !$past(vector_table_select) |->
    vector_addr == {irq_vec_num - 5'h01, 1'h0} || vector_addr == irq_vec_num - 5'h01; endproperty
  a_map: assert property (p_map) else $error("bad vector spacing");
endmodule
bind rivs_vector_sel rivs_vector_sel_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
  .boot_reset_fuse(boot_reset_fuse), .variant_wide(variant_wide), .ccr_wr(ccr_wr),
  .ccr_wdata(ccr_wdata), .instr_done(instr_done), .irq_req(irq_req), .reset_addr(reset_addr),
  .vector_addr(vector_addr), .irq_valid(irq_valid), .irq_vec_num(irq_vec_num),
  .vector_table_select(vector_table_select), .vector_change_enable(vector_change_enable),
  .irq_block(irq_block));

/* bench/rivs_core_model.sv */
// Core model issuing control writes and retire pulses
`timescale 1ns/1ns
module rivs_core_model (
  // Clock
  input wire clk,
  // Control write and retire strobes
  output reg ccr_wr,
  output reg [1:0] ccr_wdata,
  output reg instr_done
);
  initial begin
    ccr_wr = 1'h0;
    ccr_wdata = 2'h0;
    instr_done = 1'h0;
  end
  // One strobe cycle; data flips once released so stale bits never help
  task wr(input [1:0] d);
    @(posedge clk) ccr_wr <= 1'h1;
    ccr_wdata <= d;
    @(posedge clk) ccr_wr <= 1'h0;
    ccr_wdata <= ~d;
  endtask
  // Enable, new select inside the window, then one retire
  task move(input sel);
    wr(2'h1);
    wr({sel, 1'h0});
    @(posedge clk) instr_done <= 1'h1;
    @(posedge clk) instr_done <= 1'h0;
  endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the vector address selector
`timescale 1ns/1ns
`include "rivs_defs.vh"
module testbench;
  reg clk, rst, ce, fuse, wide, bsel;
  reg [24:0] req;
  reg [31:0] seed;
  reg [13:0] boot_exp;
  reg [18:0] exp_q[$];
  wire [13:0] reset_addr, vector_addr;
  wire [4:0] vec_num;
  wire [1:0] wdata;
  wire valid, sel, chg, blk, wr, done;
  integer n_fail, num_checks, cfg, k;
  rivs_vector_sel DUT (.clk(clk), .rst(rst), .ce(ce), .boot_reset_fuse(fuse),
    .variant_wide(wide), .ccr_wr(wr), .ccr_wdata(wdata), .instr_done(done), .irq_req(req),
    .reset_addr(reset_addr), .vector_addr(vector_addr), .irq_valid(valid),
    .irq_vec_num(vec_num), .vector_table_select(sel), .vector_change_enable(chg),
    .irq_block(blk));
  rivs_core_model core (.clk(clk), .ccr_wr(wr), .ccr_wdata(wdata), .instr_done(done));
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  // Lowest set bit wins; base and spacing follow select and strap
  function [18:0] expv(input [24:0] v);
    integer i;
    reg [13:0] a;
    expv = 19'h0;
    for (i = 24; i >= 0; i = i - 1)
      if (v[i]) begin
        a = bsel ? (wide ? `RIVS_BOOT_ADDR_WIDE : `RIVS_BOOT_ADDR_NARROW) : 14'h0;
        a = a + (i + 1) * (wide ? 2 : 1);
        expv = {i[4:0] + 5'h02, a};
      end
  endfunction
  task chk(input [18:0] seen, input [18:0] want);
    num_checks = num_checks + 1;
    if (seen !== want) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // One-cycle request; a note is queued only when a grant is due
  task send(input [24:0] v, input note);
    @(posedge clk) req <= v;
    if (note) exp_q.push_back(expv(v));
    @(posedge clk) req <= 25'h0;
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Grants are compared against the oldest note; no note means a stray grant
  always @(negedge clk)
    if (valid === 1'h1)
      chk({vec_num, vector_addr}, exp_q.size() ? exp_q.pop_front() : 19'h7FFFF);
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    #200000;
    n_fail = n_fail + 1;
    results;
  end
  // ----------------------------------------------------------------
  // Main sequence: every strap combination
  // ----------------------------------------------------------------
  initial begin
    {rst, ce, fuse, wide, bsel, req} = {5'h1C, 25'h0};
    seed = 32'hD7AB1C9E;
    n_fail = 0;
    num_checks = 0;
    for (cfg = 0; cfg < 4; cfg = cfg + 1) begin
      @(posedge clk) rst <= 1'h1;
      fuse <= cfg[0];
      wide <= cfg[1];
      bsel = 1'h0;
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      repeat (6) @(posedge clk);
      boot_exp = wide ? `RIVS_BOOT_ADDR_WIDE : `RIVS_BOOT_ADDR_NARROW;
      chk(reset_addr, fuse ? 14'h0 : boot_exp);
      core.wr(2'h2);
      for (k = 0; k < 50; k = k + 1) begin
        if (k == 25) begin
          core.move(1'h1);
          bsel = 1'h1;
        end
        send(25'h1 << (k % 25), 1'h1);
      end
      // Frozen cycles must not grant; a stray grant trips the monitor
      @(posedge clk) ce <= 1'h0;
      req <= 25'h4;
      repeat (3) @(posedge clk);
      ce <= 1'h1;
      req <= 25'h0;
      chk({chg, blk, sel}, 3'h1);
      repeat (20) begin
        seed = xs(seed);
        send(seed[24:0] | (seed[24:0] == 25'h0), 1'h1);
      end
      core.wr(2'h1);
      send(25'h1, 1'h0);
      chk({chg, blk}, 2'h3);
      send(25'h2, 1'h0);
      repeat (3) @(posedge clk);
      chk({chg, blk}, 2'h0);
      $display("test %0d done", cfg);
    end
    results;
  end
endmodule
